// *** acs_pkg.sv ***
// shared constants and types of the conversion sequencer
package acs_pkg;
	// clocking: core clock, internal oscillator and modulator rates
	localparam int unsigned CORE_CLK_HZ = 25_000_000;
	localparam int unsigned OSC_HZ = 1_000_000;
	localparam int unsigned OSC_DIV = CORE_CLK_HZ / OSC_HZ;
	localparam int unsigned MOD_DIV = 4;
	// serial clock low time after which the serial port resets, in ms
	localparam int unsigned SCLK_LOW_MS = 28;
	localparam int unsigned SCLK_LOW_CYC = CORE_CLK_HZ / 1000 * SCLK_LOW_MS;

	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_RESULT = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam logic [7:0] OFS_SERIAL_RX = 8'h10;

	// config field positions
	localparam int unsigned CFG_TRIG_BIT = 0;
	localparam int unsigned CFG_MODE_BIT = 1;
	localparam int unsigned CFG_MUX_LSB = 2;
	localparam int unsigned CFG_GAIN_LSB = 5;
	localparam int unsigned CFG_RATE_LSB = 8;
	// status / mask bit positions
	localparam int unsigned ST_DONE_BIT = 0;
	localparam int unsigned ST_TOUT_BIT = 1;

	// values after reset
	localparam logic RST_MODE = 1'b1;
	localparam logic [2:0] RST_MUX = 3'h0;
	localparam logic [2:0] RST_GAIN = 3'h2;
	localparam logic [2:0] RST_RATE = 3'h4;

	// readout word layout: 12-bit code left-justified in 16 bits
	localparam int unsigned CODE_W = 12;
	localparam int unsigned WORD_W = 16;

	// conversion sequencer states
	typedef enum logic [0:0] {
		ACS_POWER_DOWN,
		ACS_CONVERT
	} acs_state_e;
endpackage

// *** acs_tick_div.sv ***
// divider that turns a clock enable into a slower one-cycle enable
`timescale 1ns/1ps
module acs_tick_div #(
	parameter int unsigned DIV = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// enable in and divided enable out
	input wire logic tick_in,
	output logic tick_out
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	// a divide by zero has no meaning
	if (DIV < 1) begin : g_bad_div
		$error("acs_tick_div: DIV must be at least 1");
	end

	logic [CW-1:0] cnt_q; // position within one output period
	logic [CW-1:0] cnt_d;

	// next count, wrapping at the last position
	always_comb begin
		cnt_d = cnt_q;
		if (tick_in) begin
			cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
		end
	end

	// count register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// pulse on the last input tick of each period
	assign tick_out = tick_in && (cnt_q == LAST);
endmodule // acs_tick_div

// *** acs_sequencer.sv ***
// Operation
// - single-shot: one conversion per request, then power-down
// - continuous: next conversion starts when previous ends
// - reads always return latest completed conversion
// - mux field picks single, differential or versus-input-three
// - single-ended selection grounds negative converter input
// - single-ended measurement never reports negative codes
// - modulator clock is oscillator divided by four
// - gain field picks one of six ranges
// - code step equals range over two to twelfth
// - data out driven on select, updated, released
// - mode one single-shot, zero continuous, reset single-shot
// - trigger write starts conversion, self-clears, ignored busy
// - serial clock low too long resets serial port
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module acs_sequencer #(
	parameter int unsigned SCLK_LOW_CYCLES = acs_pkg::SCLK_LOW_CYC,
	parameter int unsigned TOUT_W = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// interrupt
	output logic irq,
	// serial pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_din,
	output logic serial_out_with_ready_flag,
	output logic serial_out_oe_n,
	// converter core
	input wire logic [11:0] conv_code,
	output logic mod_clk_en,
	output logic conv_powered,
	output logic [1:0] mux_pos_sel,
	output logic [1:0] mux_neg_sel,
	output logic mux_neg_to_ground,
	output logic [2:0] gain_range_select,
	output logic [4:0] lsb_weight_eighth_mv
);
	// timeout counter must be able to hold the limit
	if (SCLK_LOW_CYCLES < 1 || SCLK_LOW_CYCLES >= (64'd1 << TOUT_W))
	begin : g_bad_tout
		$error("acs_sequencer: SCLK_LOW_CYCLES does not fit TOUT_W");
	end

	// modulator ticks per conversion for each rate code
	function automatic logic [10:0] rate_ticks(input logic [2:0] rate);
		unique case (rate)
			3'h0: rate_ticks = 11'h7A1; // 128 per second
			3'h1: rate_ticks = 11'h3E8; // 250
			3'h2: rate_ticks = 11'h1FE; // 490
			3'h3: rate_ticks = 11'h10F; // 920
			3'h4: rate_ticks = 11'h09C; // 1600
			3'h5: rate_ticks = 11'h068; // 2400
			3'h6: rate_ticks = 11'h04B; // 3300
			3'h7: rate_ticks = 11'h04B; // spare code runs at top rate
		endcase
	endfunction

	// step weight in eighths of a millivolt: range halves each code from one to five
	function automatic logic [4:0] lsb_weight(input logic [2:0] gain);
		unique case (gain)
			3'h0: lsb_weight = 5'h18; // 3 mV
			3'h1: lsb_weight = 5'h10; // 2 mV
			3'h2: lsb_weight = 5'h08; // 1 mV
			3'h3: lsb_weight = 5'h04; // 0.5 mV
			3'h4: lsb_weight = 5'h02; // 0.25 mV
			default: lsb_weight = 5'h01; // 0.125 mV, codes 5 to 7
		endcase
	endfunction

	// codes four and up measure one input against ground
	function automatic logic is_single(input logic [2:0] mux);
		is_single = mux[2];
	endfunction

	// oscillator and modulator enables
	logic osc_tick;
	logic mod_tick;

	acs_tick_div #(.DIV(acs_pkg::OSC_DIV)) u_osc_div (
		.core_clk(core_clk),
		.srst(srst),
		.tick_in(1'b1),
		.tick_out(osc_tick)
	);

	acs_tick_div #(.DIV(acs_pkg::MOD_DIV)) u_mod_div (
		.core_clk(core_clk),
		.srst(srst),
		.tick_in(osc_tick),
		.tick_out(mod_tick)
	);

	// configuration and interrupt registers
	logic trig_q, trig_d; // pending single-shot request
	logic mode_q, mode_d; // 1 single-shot, 0 continuous
	logic [2:0] mux_q, mux_d; // input pair selection
	logic [2:0] gain_q, gain_d; // range selection
	logic [2:0] rate_q, rate_d; // data rate code
	logic [1:0] stat_q, stat_d; // sticky events
	logic [1:0] mask_q, mask_d; // interrupt enables
	logic [31:0] rdata_q, rdata_d; // read data, one cycle after strobe
	// sequencer
	acs_pkg::acs_state_e st_q, st_d;
	logic [10:0] tick_cnt_q, tick_cnt_d; // modulator ticks so far
	logic [15:0] result_q, result_d; // held readout word
	logic new_data_q, new_data_d; // result not yet shifted out
	logic conv_done; // one-cycle completion pulse
	logic conv_start; // one-cycle start pulse
	// serial port
	logic cs_s1_q, cs_s2_q, cs_s3_q; // chip select synchroniser
	logic ck_s1_q, ck_s2_q, ck_s3_q; // serial clock synchroniser
	logic di_s1_q, di_s2_q; // data in synchroniser
	logic [15:0] shift_q, shift_d; // locked word being sent
	logic [15:0] rx_q, rx_d; // bits coming in
	logic [15:0] rx_word_q, rx_word_d; // last full word received
	logic [3:0] rx_cnt_q, rx_cnt_d;
	logic dout_q, dout_d;
	logic oe_n_q, oe_n_d;
	logic [TOUT_W-1:0] low_cnt_q, low_cnt_d; // serial clock low time
	logic sclk_rise, sclk_fall, cs_fall, cs_rise, spi_tout, first_bit_out;

	// edges seen between stages two and three only
	assign sclk_rise = ck_s2_q && !ck_s3_q;
	assign sclk_fall = !ck_s2_q && ck_s3_q;
	assign cs_fall = !cs_s2_q && cs_s3_q;
	assign cs_rise = cs_s2_q && !cs_s3_q;
	assign spi_tout = !cs_s2_q && !ck_s2_q &&
		(low_cnt_q == TOUT_W'(SCLK_LOW_CYCLES));

	// register writes, event flags and read mux
	always_comb begin
		trig_d = trig_q;
		mode_d = mode_q;
		mux_d = mux_q;
		gain_d = gain_q;
		rate_d = rate_q;
		mask_d = mask_q;
		stat_d = stat_q;
		rdata_d = 32'h0000_0000;
		if (reg_wr) begin
			unique case (reg_addr)
				acs_pkg::OFS_CONFIG: begin
					mode_d = reg_wdata[acs_pkg::CFG_MODE_BIT];
					mux_d = reg_wdata[acs_pkg::CFG_MUX_LSB +: 3];
					gain_d = reg_wdata[acs_pkg::CFG_GAIN_LSB +: 3];
					rate_d = reg_wdata[acs_pkg::CFG_RATE_LSB +: 3];
					// a request while busy is dropped
					if (reg_wdata[acs_pkg::CFG_TRIG_BIT] &&
						st_q == acs_pkg::ACS_POWER_DOWN) begin
						trig_d = 1'b1;
					end
				end
				acs_pkg::OFS_STATUS: stat_d = stat_q & ~reg_wdata[1:0];
				acs_pkg::OFS_MASK: mask_d = reg_wdata[1:0];
				default: ; // unmapped writes are ignored
			endcase
		end
		// the sequencer takes the request and clears it
		if (conv_start) begin
			trig_d = 1'b0;
		end
		// a new event wins over a clear in the same cycle
		if (conv_done) begin
			stat_d[acs_pkg::ST_DONE_BIT] = 1'b1;
		end
		if (spi_tout) begin
			stat_d[acs_pkg::ST_TOUT_BIT] = 1'b1;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				acs_pkg::OFS_CONFIG: rdata_d = {21'h0, rate_q, gain_q,
					mux_q, mode_q, trig_q};
				acs_pkg::OFS_RESULT: rdata_d = {16'h0, result_q};
				acs_pkg::OFS_STATUS: rdata_d = {30'h0, stat_q};
				acs_pkg::OFS_MASK: rdata_d = {30'h0, mask_q};
				acs_pkg::OFS_SERIAL_RX: rdata_d = {16'h0, rx_word_q};
				default: rdata_d = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// register file state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			trig_q <= 1'b0;
			mode_q <= acs_pkg::RST_MODE;
			mux_q <= acs_pkg::RST_MUX;
			gain_q <= acs_pkg::RST_GAIN;
			rate_q <= acs_pkg::RST_RATE;
			stat_q <= 2'h0;
			mask_q <= 2'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			trig_q <= trig_d;
			mode_q <= mode_d;
			mux_q <= mux_d;
			gain_q <= gain_d;
			rate_q <= rate_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
		end
	end

	// conversion sequencing and result capture
	always_comb begin
		st_d = st_q;
		tick_cnt_d = tick_cnt_q;
		result_d = result_q;
		new_data_d = new_data_q;
		conv_start = 1'b0;
		conv_done = 1'b0;
		unique case (st_q)
			acs_pkg::ACS_POWER_DOWN: begin
				// continuous mode leaves power-down at once
				if (trig_q || !mode_q) begin
					conv_start = 1'b1;
					st_d = acs_pkg::ACS_CONVERT;
					tick_cnt_d = 11'h000;
				end
			end
			acs_pkg::ACS_CONVERT: begin
				if (mod_tick) begin
					if (tick_cnt_q == rate_ticks(rate_q) - 11'h001) begin
						conv_done = 1'b1;
						tick_cnt_d = 11'h000;
						// back-to-back unless single-shot
						st_d = mode_q ? acs_pkg::ACS_POWER_DOWN
							: acs_pkg::ACS_CONVERT;
					end else begin
						tick_cnt_d = tick_cnt_q + 11'h001;
					end
				end
			end
		endcase
		// only a finished conversion replaces the held word
		if (conv_done) begin
			new_data_d = 1'b1;
			if (is_single(mux_q) && conv_code[11]) begin
				result_d = 16'h0000;
			end else begin
				result_d = {conv_code, 4'h0};
			end
		end else if (sclk_rise && first_bit_out) begin
			new_data_d = 1'b0; // transfer has taken the word
		end
	end

	// sequencer state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= acs_pkg::ACS_POWER_DOWN;
			tick_cnt_q <= 11'h000;
			result_q <= 16'h0000;
			new_data_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tick_cnt_q <= tick_cnt_d;
			result_q <= result_d;
			new_data_q <= new_data_d;
		end
	end

	// first rising edge of a frame carries the data ready flag away
	assign first_bit_out = !oe_n_q && (rx_cnt_q == 4'h0) &&
		(shift_q == result_q);

	// serial port: lock word at select, shift out, collect input
	always_comb begin
		shift_d = shift_q;
		rx_d = rx_q;
		rx_cnt_d = rx_cnt_q;
		rx_word_d = rx_word_q;
		dout_d = dout_q;
		oe_n_d = oe_n_q;
		low_cnt_d = low_cnt_q;
		// low time counter runs only while selected and clock low
		if (cs_s2_q || ck_s2_q || spi_tout) begin
			low_cnt_d = '0;
		end else begin
			low_cnt_d = low_cnt_q + TOUT_W'(1);
		end
		if (cs_rise) begin
			oe_n_d = 1'b1;
			rx_cnt_d = 4'h0;
		end else if (cs_fall || spi_tout) begin
			// locked word stays put while the frame runs
			shift_d = result_q;
			oe_n_d = 1'b0;
			dout_d = !new_data_q; // low means fresh data
			rx_cnt_d = 4'h0;
		end else if (!cs_s2_q) begin
			if (sclk_rise) begin
				dout_d = shift_q[15];
				shift_d = {shift_q[14:0], 1'b0};
			end
			if (sclk_fall) begin
				rx_d = {rx_q[14:0], di_s2_q};
				rx_cnt_d = rx_cnt_q + 4'h1;
				if (rx_cnt_q == 4'hF) begin
					rx_word_d = {rx_q[14:0], di_s2_q};
				end
			end
		end
	end

	// serial port state and pin synchronisers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
			di_s1_q <= 1'b0;
			di_s2_q <= 1'b0;
			shift_q <= 16'h0000;
			rx_q <= 16'h0000;
			rx_cnt_q <= 4'h0;
			rx_word_q <= 16'h0000;
			dout_q <= 1'b1;
			oe_n_q <= 1'b1;
			low_cnt_q <= '0;
		end else begin
			cs_s1_q <= spi_cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			ck_s1_q <= spi_sclk;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
			di_s1_q <= spi_din;
			di_s2_q <= di_s1_q;
			shift_q <= shift_d;
			rx_q <= rx_d;
			rx_cnt_q <= rx_cnt_d;
			rx_word_q <= rx_word_d;
			dout_q <= dout_d;
			oe_n_q <= oe_n_d;
			low_cnt_q <= low_cnt_d;
		end
	end

	// outputs
	assign reg_rdata = rdata_q;
	assign irq = |(stat_q & mask_q);
	assign serial_out_with_ready_flag = dout_q;
	assign serial_out_oe_n = oe_n_q;
	assign mod_clk_en = mod_tick && (st_q == acs_pkg::ACS_CONVERT);
	assign conv_powered = (st_q == acs_pkg::ACS_CONVERT);
	assign gain_range_select = (gain_q > 3'h5) ? 3'h5 : gain_q;
	assign lsb_weight_eighth_mv = lsb_weight(gain_q);

	// input pair decode
	always_comb begin
		mux_pos_sel = 2'h0;
		mux_neg_sel = 2'h3;
		mux_neg_to_ground = 1'b0;
		unique case (mux_q)
			3'h0: begin
				mux_pos_sel = 2'h0;
				mux_neg_sel = 2'h1;
			end
			3'h1: mux_pos_sel = 2'h0;
			3'h2: mux_pos_sel = 2'h1;
			3'h3: mux_pos_sel = 2'h2;
			default: begin
				mux_pos_sel = mux_q[1:0];
				mux_neg_to_ground = 1'b1;
			end
		endcase
	end
endmodule // acs_sequencer

// *** acs_assertions.sv ***
// port checker of the conversion sequencer, bound to its top module
`timescale 1ns/1ps
module acs_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// serial side
	input wire logic spi_cs_n,
	input wire logic serial_out_oe_n,
	// converter side
	input wire logic mod_clk_en,
	input wire logic conv_powered,
	input wire logic [1:0] mux_pos_sel,
	input wire logic [1:0] mux_neg_sel,
	input wire logic mux_neg_to_ground,
	input wire logic [2:0] gain_range_select,
	input wire logic [4:0] lsb_weight_eighth_mv
);
	// step weight per range code, in eighths of a millivolt
	localparam logic [4:0] WT [8] = '{5'h18, 5'h10, 5'h08, 5'h04,
		5'h02, 5'h01, 5'h01, 5'h01};
	logic cfg_wr; // config write in this cycle
	logic mode_q; // mode bit as last written, one is single-shot
	assign cfg_wr = reg_wr && reg_addr == acs_pkg::OFS_CONFIG;
	// mirror the mode bit from the bus so no internal probe is needed
	always_ff @(posedge core_clk)
		mode_q <= srst ? 1'b1 : (cfg_wr ? reg_wdata[1] : mode_q);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	AST_MOD_POWERED: assert property (conv_powered |->
		##[0:99] (mod_clk_en || !conv_powered))
		else $error("no modulator tick while converting");
	AST_MOD_PERIOD: assert property (mod_clk_en |->
		##100 (mod_clk_en || !conv_powered))
		else $error("modulator tick not one hundred cycles apart");
	AST_NEG_PAIR: assert property (!mux_neg_to_ground |->
		mux_neg_sel[0] && mux_pos_sel != mux_neg_sel)
		else $error("differential pair selection out of table");
	AST_STEP_WEIGHT: assert property (
		lsb_weight_eighth_mv == WT[gain_range_select])
		else $error("step weight does not match range");
	AST_CS_RELEASE: assert property (spi_cs_n [*6] |-> serial_out_oe_n)
		else $error("data out still driven after select rose");
	AST_TRIG_POWERS: assert property (
		cfg_wr && reg_wdata[0] && !conv_powered |-> ##2 conv_powered)
		else $error("trigger write did not start a conversion");
	AST_CONT_RUNS: assert property (
		!mode_q && !cfg_wr && conv_powered |=> conv_powered)
		else $error("continuous mode powered down");
	AST_RESULT_LAYOUT: assert property (
		reg_rd && reg_addr == acs_pkg::OFS_RESULT |=>
		reg_rdata[3:0] == 4'h0 && reg_rdata[31:16] == 16'h0000)
		else $error("result word not left-justified");
	// main scenarios
	COV_CONT: cover property (conv_powered && !mode_q);
	COV_FRAME: cover property (!serial_out_oe_n);
	COV_SINGLE_END: cover property (mux_neg_to_ground && conv_powered);
endmodule // acs_assertions

bind acs_sequencer acs_assertions acs_chk (
	.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .spi_cs_n(spi_cs_n),
	.serial_out_oe_n(serial_out_oe_n), .mod_clk_en(mod_clk_en),
	.conv_powered(conv_powered), .mux_pos_sel(mux_pos_sel),
	.mux_neg_sel(mux_neg_sel), .mux_neg_to_ground(mux_neg_to_ground),
	.gain_range_select(gain_range_select),
	.lsb_weight_eighth_mv(lsb_weight_eighth_mv)
);

// *** acs_host.sv ***
// serial host model that runs sixteen-bit frames
`timescale 1ns/1ps
module acs_host (
	// clock
	input wire logic core_clk,
	// serial pins
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_din,
	input wire logic serial_out_with_ready_flag
);
	localparam int H = 6; // half serial period, in core cycles
	initial begin
		spi_cs_n = 1'b1; // pulled up while idle
		spi_sclk = 1'b0; // stands still outside frames
		spi_din = 1'b0;
	end
	// ready flag, then sixteen bits each way, msb first
	task automatic frame(input logic [15:0] tx, output logic rdy,
		output logic [15:0] rx);
		@(posedge core_clk);
		spi_cs_n <= 1'b0;
		repeat (H) @(posedge core_clk);
		#1 rdy = serial_out_with_ready_flag;
		for (int i = 15; i >= 0; i--) begin
			spi_sclk <= 1'b1;
			spi_din <= tx[i];
			repeat (H) @(posedge core_clk);
			// read after the edge has settled, never in its time step
			#1 rx[i] = serial_out_with_ready_flag;
			spi_sclk <= 1'b0;
			repeat (H) @(posedge core_clk);
		end
		spi_cs_n <= 1'b1;
		spi_din <= ~tx[0]; // released line no longer shows last bit
		repeat (H) @(posedge core_clk);
	endtask
	// select held with the clock low, long enough to reset the port
	task automatic stall(input int n);
		@(posedge core_clk);
		spi_cs_n <= 1'b0;
		repeat (n) @(posedge core_clk);
		spi_cs_n <= 1'b1;
	endtask
endmodule // acs_host

// *** adc_conversion_sequencer_test.sv ***
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
	logic core_clk, srst, reg_wr, reg_rd, irq, oe_n, dout, sdo;
	logic cs_n, sclk, din, mod_en, pwr, gnd, rd_d, rdy;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cfg;
	logic [11:0] conv_code, code;
	logic [1:0] psel, nsel;
	logic [2:0] gain, mx;
	logic [4:0] wt;
	logic [15:0] tx, rx;
	logic [31:0] exp_q [$]; // expected read data, oldest first
	int err_total, check_count;
	time t_irq, t0; // times at which the completion interrupt was seen
	int seed = 32'hd5a4b8a5;
	localparam logic [4:0] WT [8] = '{5'h18, 5'h10, 5'h08, 5'h04,
		5'h02, 5'h01, 5'h01, 5'h01};
	// {positive, negative} input per selection code; {0, positive} for codes four and up
	localparam logic [3:0] MX [8] = '{4'h1, 4'h3, 4'h7, 4'hB,
		4'h0, 4'h1, 4'h2, 4'h3};
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// released data line floats, so a late drive shows up as z
	assign sdo = oe_n ? 1'bZ : dout;
	acs_sequencer #(.SCLK_LOW_CYCLES(50)) dut (
		.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .spi_cs_n(cs_n),
		.spi_sclk(sclk), .spi_din(din), .serial_out_with_ready_flag(dout),
		.serial_out_oe_n(oe_n), .conv_code(conv_code), .mod_clk_en(mod_en),
		.conv_powered(pwr), .mux_pos_sel(psel), .mux_neg_sel(nsel),
		.mux_neg_to_ground(gnd), .gain_range_select(gain),
		.lsb_weight_eighth_mv(wt));
	acs_host host (.core_clk(core_clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
		.spi_din(din), .serial_out_with_ready_flag(sdo));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read strobe; the monitor judges the answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// bounded wait for the completion interrupt
	task automatic wait_irq();
		// a status clear issued by the last write lands on this edge only
		@(negedge core_clk);
		for (int n = 0; irq !== 1'b1; n++) begin
			@(negedge core_clk);
			if (n > 9000) begin
				chk(irq, 1);
				report_and_stop();
			end
		end
		t_irq = $time;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_d <= reg_rd;
		if (rd_d && exp_q.size() > 0)
			chk(reg_rdata, exp_q.pop_front());
	end
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		conv_code = 12'h000;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		rd(acs_pkg::OFS_CONFIG, 32'h442);
		rd(8'h20, 32'h0);
		$display("reset values done");
		for (int g = 0; g < 8; g++) begin
			wr(acs_pkg::OFS_CONFIG, 32'(g * 36 + 2));
			@(negedge core_clk);
			chk(gain, g > 5 ? 5 : g);
			chk(wt, WT[g]);
			chk(gnd, g / 4);
			chk(g < 4 ? {psel, nsel} : {2'h0, psel}, MX[g]);
		end
		$display("range and input selection done");
		wr(acs_pkg::OFS_MASK, 32'h1);
		for (int k = 0; k < 2; k++) begin
			code = 12'($random(seed));
			mx = k ? 3'h0 : 3'h4;
			if (k == 0)
				code[11] = 1'b1; // negative code on a grounded input
			@(posedge core_clk);
			conv_code <= code;
			cfg = {21'h0, 3'h7, 3'h2, mx, 2'h3};
			wr(acs_pkg::OFS_CONFIG, cfg);
			rd(acs_pkg::OFS_CONFIG, cfg & 32'hFFFFFFFE);
			wr(acs_pkg::OFS_CONFIG, cfg);
			wait_irq();
			repeat (3) @(negedge core_clk);
			chk(pwr, 0);
			rd(acs_pkg::OFS_RESULT, k ? {16'h0, code, 4'h0} : 32'h0);
			wr(acs_pkg::OFS_MASK, 32'h0);
			@(negedge core_clk);
			chk(irq, 0);
			rd(acs_pkg::OFS_STATUS, 32'h1);
			wr(acs_pkg::OFS_STATUS, 32'h1);
			wr(acs_pkg::OFS_MASK, 32'h1);
		end
		$display("single-shot done");
		tx = 16'($random(seed));
		host.frame(tx, rdy, rx);
		chk(rdy, 0);
		chk(rx, {code, 4'h0});
		rd(acs_pkg::OFS_SERIAL_RX, {16'h0, tx});
		host.frame(~tx, rdy, rx);
		chk(rdy, 1);
		chk(rx, {code, 4'h0});
		chk(oe_n, 1);
		host.stall(60);
		rd(acs_pkg::OFS_STATUS, 32'h2);
		wr(acs_pkg::OFS_STATUS, 32'h2);
		$display("serial done");
		code = 12'($random(seed));
		@(posedge core_clk);
		conv_code <= code;
		wr(acs_pkg::OFS_CONFIG, 32'h700);
		wait_irq();
		@(posedge core_clk);
		conv_code <= ~code;
		t0 = t_irq;
		rd(acs_pkg::OFS_RESULT, {16'h0, code, 4'h0});
		wr(acs_pkg::OFS_STATUS, 32'h1);
		wait_irq();
		chk(pwr, 1);
		// top rate code: 75 modulator ticks per result, 40 ns per cycle
		chk(32'((t_irq - t0) / 40),
			75 * acs_pkg::OSC_DIV * acs_pkg::MOD_DIV);
		rd(acs_pkg::OFS_RESULT, {16'h0, ~code, 4'h0});
		repeat (2) @(posedge core_clk);
		$display("continuous done");
		report_and_stop();
	end
endmodule // adc_conversion_sequencer_test
